// ==== design/gia_regs.svh ====
// Register offsets, field positions and reset values of the global interrupt aggregator
// Summary of operation
// - Mask bit 31 blocks lookup engine interrupt.
// - Mask bit 30 blocks trigger/timestamp interrupt.
// - Masks gate irq only, not status; bits 29:0 read-only.
// - Port summary bit n-1 reports port n.
// - Summary bits follow port status, no latching.
// - Port mask bit n-1 disables port n.
// - All mask bits reset to zero.
// - Port summary has no reset value; it reads live port levels.
// - Global status bits 31, 30 report sources.
`ifndef GIA_REGS_SVH
`define GIA_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define GIA_OFS_GLOBAL_STATUS 16'h0010
`define GIA_OFS_GLOBAL_MASK 16'h0014
`define GIA_OFS_PORT_STATUS 16'h0018
`define GIA_OFS_PORT_MASK 16'h001C

// ****************************************
// Field positions
// ****************************************
`define GIA_BIT_LOOKUP_ENGINE 31
`define GIA_BIT_TRIG_TS 30
`define GIA_NUM_PORTS 7

// ****************************************
// Reset values
// ****************************************
`define GIA_RST_GMASK 2'h0
`define GIA_RST_PMASK 7'h00
`define GIA_RST_RDATA 32'h0000_0000

`endif

// ==== design/gia_pkg.sv ====
// Types shared by the global interrupt aggregator and its bench
package gia_pkg;

	// Register access request from the management interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} gia_req_t;

	// Interrupt request levels from the switch units
	typedef struct packed {
		logic lookup_engine;
		logic trig_ts;
		logic [6:0] port;
	} gia_src_t;

	// Registered read answer
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} gia_rsp_t;

endpackage

// ==== design/gia_top.sv ====
// Global interrupt aggregator: source masks, port summary and combined interrupt request
`include "gia_regs.svh"

module gia_top (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Register access from the management interface
	input wire gia_pkg::gia_req_t req_i,
	output gia_pkg::gia_rsp_t rsp_o,
	// Interrupt sources from the switch units
	input wire gia_pkg::gia_src_t src_i,
	// Combined interrupt request, active high
	output logic irq_o
);

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n = rst_sync[1];

	// ****************************************
	// Mask registers
	// ****************************************
	logic [1:0] gmask;
	logic [1:0] next_gmask;
	logic [`GIA_NUM_PORTS-1:0] pmask;
	logic [`GIA_NUM_PORTS-1:0] next_pmask;
	logic wr_gmask;
	logic wr_pmask;

	assign wr_gmask = ce_i && req_i.wr && (req_i.addr == `GIA_OFS_GLOBAL_MASK);
	assign wr_pmask = ce_i && req_i.wr && (req_i.addr == `GIA_OFS_PORT_MASK);

	always_comb begin
		next_gmask = gmask;
		next_pmask = pmask;
		if (wr_gmask) begin
			// Only bits 31 and 30 are writable; the rest are ignored
			next_gmask = {req_i.wdata[`GIA_BIT_LOOKUP_ENGINE],
				req_i.wdata[`GIA_BIT_TRIG_TS]};
		end
		if (wr_pmask) begin
			next_pmask = req_i.wdata[`GIA_NUM_PORTS-1:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			gmask <= `GIA_RST_GMASK;
			pmask <= `GIA_RST_PMASK;
		end else if (ce_i) begin
			gmask <= next_gmask;
			pmask <= next_pmask;
		end
	end

	// ****************************************
	// Status views and combined request
	// ****************************************
	logic [31:0] gstat_word;
	logic [31:0] pstat_word;
	logic [31:0] gmask_word;
	logic [31:0] pmask_word;
	logic next_irq;

	always_comb begin
		gstat_word = 32'h0000_0000;
		gstat_word[`GIA_BIT_LOOKUP_ENGINE] = src_i.lookup_engine;
		gstat_word[`GIA_BIT_TRIG_TS] = src_i.trig_ts;
		gmask_word = 32'h0000_0000;
		gmask_word[`GIA_BIT_LOOKUP_ENGINE] = gmask[1];
		gmask_word[`GIA_BIT_TRIG_TS] = gmask[0];
		// Summary follows the port's own status live, no flag of its own
		pstat_word = {25'h0000000, src_i.port};
		pmask_word = {25'h0000000, pmask};
	end

	always_comb begin
		next_irq = (src_i.lookup_engine && !gmask[1])
			|| (src_i.trig_ts && !gmask[0])
			|| (|(src_i.port & ~pmask));
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= next_irq;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	gia_pkg::gia_rsp_t next_rsp;

	always_comb begin
		next_rsp.valid = req_i.rd;
		next_rsp.data = `GIA_RST_RDATA;
		if (req_i.rd) begin
			unique case (req_i.addr)
				`GIA_OFS_GLOBAL_STATUS: begin
					next_rsp.data = gstat_word;
				end
				`GIA_OFS_GLOBAL_MASK: begin
					next_rsp.data = gmask_word;
				end
				`GIA_OFS_PORT_STATUS: begin
					next_rsp.data = pstat_word;
				end
				`GIA_OFS_PORT_MASK: begin
					next_rsp.data = pmask_word;
				end
				default: begin
					next_rsp.data = `GIA_RST_RDATA;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rsp_o <= '0;
		end else if (ce_i) begin
			rsp_o <= next_rsp;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence wr_gmask_s;
		wr_gmask;
	endsequence

	sequence rd_at_s(logic [15:0] ofs);
		ce_i && req_i.rd && (req_i.addr == ofs);
	endsequence

	lookup_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_gmask_s ##1 ce_i && src_i.lookup_engine && gmask[1]
		&& !src_i.trig_ts && (src_i.port == 7'h00) |=> !irq_o)
		else $error("masked lookup engine request reached irq");

	trig_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_gmask_s |=> gmask[0] == $past(req_i.wdata[`GIA_BIT_TRIG_TS]))
		else $error("trigger mask bit not written from bit 30");

	gmask_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		rd_at_s(`GIA_OFS_GLOBAL_MASK) |=> rsp_o.valid && (rsp_o.data[29:0] == 30'h0)
		&& (rsp_o.data[31:30] == $past(gmask)))
		else $error("global mask readback wrong");

	port_status_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		rd_at_s(`GIA_OFS_PORT_STATUS) |=> rsp_o.valid
		&& (rsp_o.data == {25'h0000000, $past(src_i.port)}))
		else $error("port summary readback wrong");

	port_live_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		rd_at_s(`GIA_OFS_PORT_STATUS) ##1 rd_at_s(`GIA_OFS_PORT_STATUS)
		##0 $fell(src_i.port[0]) |=> !rsp_o.data[0])
		else $error("port summary bit held after source dropped");

	port_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_pmask |=> (pmask == $past(req_i.wdata[6:0]))
		##1 (!$past(ce_i) || !$past(src_i.port[0]) || $past(pmask[0]) || irq_o))
		else $error("port mask write or gating wrong");

	mask_reset_a: assert property (@(posedge clk_i)
		$rose(rst_n) |-> (gmask == 2'h0) && (pmask == 7'h00))
		else $error("masks not zero after reset");

	rsp_reset_a: assert property (@(posedge clk_i)
		$rose(rst_n) |-> !rsp_o.valid && (rsp_o.data == 32'h0000_0000) && !irq_o)
		else $error("read answer or irq not clear after reset");

	gstat_read_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		rd_at_s(`GIA_OFS_GLOBAL_STATUS) |=> rsp_o.data
		== {$past(src_i.lookup_engine), $past(src_i.trig_ts), 30'h0})
		else $error("global status readback wrong");

	irq_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		ce_i |=> irq_o == $past((src_i.lookup_engine && !gmask[1])
		|| (src_i.trig_ts && !gmask[0]) || (|(src_i.port & ~pmask))))
		else $error("irq does not follow unmasked requests");

	sequence all_masked_s;
		ce_i && (gmask == 2'h3) && (pmask == 7'h7F);
	endsequence

	all_masked_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		all_masked_s |=> !irq_o)
		else $error("irq raised with every source masked");

	gmask_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		ce_i && !wr_gmask |=> gmask == $past(gmask))
		else $error("global mask changed without a write");

	pmask_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		ce_i && !wr_pmask |=> pmask == $past(pmask))
		else $error("port mask changed without a write");

	rsp_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		ce_i && !req_i.rd |=> !rsp_o.valid && (rsp_o.data == 32'h0000_0000))
		else $error("read answer not idle without a read");

	enable_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		!ce_i |=> (gmask == $past(gmask)) && (pmask == $past(pmask))
		&& (irq_o == $past(irq_o)) && (rsp_o == $past(rsp_o)))
		else $error("state moved while clock enable low");

endmodule // gia_top

// ==== dv/gia_src_model.sv ====
// Behavioural model of the switch units that raise interrupt request levels
module gia_src_model (
	// Clock
	input wire logic clk_i,
	// Levels asked for by the bench: lookup, trigger, ports 7..1
	input wire logic [8:0] lvl_i,
	// Request levels toward the aggregator
	output gia_pkg::gia_src_t src_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// Each unit copies the bench level at every rising clock edge, 1 ns later
	always @(posedge clk_i) begin
		src_o <= #1 lvl_i;
	end
endmodule // gia_src_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the global interrupt aggregator
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	gia_pkg::gia_req_t req_i = '0;
	gia_pkg::gia_rsp_t rsp_o;
	gia_pkg::gia_src_t src_i;
	logic irq_o;
	logic [8:0] lvl = 9'h000;
	int errors = 0;
	int tests_run = 0;
	int i;

	always #5 clk_i = ~clk_i;

	gia_src_model src_u (.clk_i(clk_i), .lvl_i(lvl), .src_o(src_i));

	gia_top dut_u (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.req_i(req_i),
		.rsp_o(rsp_o),
		.src_i(src_i),
		.irq_o(irq_o)
	);

	// ****************************************
	// Helper tasks
	// ****************************************
	task automatic end_sim;
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		cyc(1);
		req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		cyc(1);
		req_i.wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		int n;
		cyc(1);
		req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		cyc(1);
		req_i.rd = 1'b0;
		n = 0;
		while (rsp_o.valid !== 1'b1 && n < 4) begin
			cyc(1);
			n++;
		end
		if (rsp_o.valid !== 1'b1) begin
			errors++;
			end_sim();
		end else begin
			check("read data", rsp_o.data, exp);
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		cyc(6);
		rstn_i = 1'b1;
		cyc(3);
		check("irq after reset", {31'h0, irq_o}, 32'h0000_0000);
		rd(16'h0014, 32'h0000_0000);
		rd(16'h001C, 32'h0000_0000);
		rd(16'h0018, 32'h0000_0000);
		lvl = 9'h1FF;
		cyc(3);
		check("irq all raised", {31'h0, irq_o}, 32'h0000_0001);
		rd(16'h0010, 32'hC000_0000);
		wr(16'h0018, 32'h0000_0000);
		rd(16'h0018, 32'h0000_007F);
		wr(16'h0014, 32'hFFFF_FFFF);
		rd(16'h0014, 32'hC000_0000);
		wr(16'h001C, 32'hFFFF_FFFF);
		rd(16'h001C, 32'h0000_007F);
		cyc(1);
		check("irq all masked", {31'h0, irq_o}, 32'h0000_0000);
		// Enable one source at a time, then let it drop
		for (i = 0; i < 9; i++) begin
			wr(16'h0014, {~(i == 8), ~(i == 7), 30'h0});
			wr(16'h001C, 32'h0000_007F ^ (32'h1 << i));
			cyc(1);
			check("irq one enabled", {31'h0, irq_o}, 32'h0000_0001);
			lvl[i] = 1'b0;
			cyc(2);
			check("irq source gone", {31'h0, irq_o}, 32'h0000_0000);
		end
		rd(16'h0018, 32'h0000_0000);
		rd(16'h0010, 32'h0000_0000);
		rd(16'h0020, 32'h0000_0000);
		// Lookup engine alone, masked
		lvl = 9'h100;
		wr(16'h0014, 32'h8000_0000);
		cyc(2);
		check("irq lookup masked", {31'h0, irq_o}, 32'h0000_0000);
		// Write with clock enable low must not land
		ce_i = 1'b0;
		lvl = 9'h101;
		wr(16'h001C, 32'h0000_0000);
		cyc(2);
		check("irq frozen", {31'h0, irq_o}, 32'h0000_0000);
		ce_i = 1'b1;
		cyc(2);
		check("irq port still masked", {31'h0, irq_o}, 32'h0000_0000);
		rd(16'h001C, 32'h0000_007F);
		// Back-to-back summary reads across a dropping source
		req_i = '{wr: 1'b0, rd: 1'b1, addr: 16'h0018, wdata: 32'h0000_0000};
		lvl = 9'h000;
		cyc(1);
		check("summary while raised", rsp_o.data, 32'h0000_0001);
		cyc(1);
		check("summary after drop", rsp_o.data, 32'h0000_0000);
		req_i.rd = 1'b0;
		cyc(1);
		// Reset in mid-run clears the masks again
		rstn_i = 1'b0;
		cyc(2);
		rstn_i = 1'b1;
		cyc(3);
		rd(16'h0014, 32'h0000_0000);
		rd(16'h001C, 32'h0000_0000);
		end_sim();
	end
endmodule // tb_top
